//--- cfg_pkg.sv
// constants, types and field layout of the configuration word decoder
// assumes a 14-bit configuration word and a 14-bit program memory word
package cfg_pkg;
  localparam int          WORD_W          = 14;
  localparam int          ADDR_W          = 14;
  localparam logic [13:0] CONFIG_ADDR     = 14'h2007;
  localparam logic [13:0] SPECIAL_LO      = 14'h2000;
  localparam logic [13:0] SPECIAL_HI      = 14'h3FFF;
  localparam logic [13:0] LAST_PROG_ADDR  = 14'h03FF;
  localparam logic [13:0] CONFIG_RESET    = 14'h31FF;
  localparam logic [13:0] CONFIG_IMPL     = 14'h31FF;
  localparam logic [7:0]  TRIM_RESET      = 8'h80;
  localparam logic [5:0]  RET_LIT_OPCODE  = 6'h34;
  localparam int          BIT_OSC_SEL_LO  = 0;
  localparam int          BIT_WATCHDOG    = 3;
  localparam int          BIT_POWERUP     = 4;
  localparam int          BIT_RESET_PIN   = 5;
  localparam int          BIT_BROWNOUT    = 6;
  localparam int          BIT_PROG_PROT   = 7;
  localparam int          BIT_DATA_PROT   = 8;
  localparam int          BIT_BG_LO       = 12;
  localparam int          OSC_START_CYCLES = 1024;
  localparam int          DIVCLK_RATIO     = 4;
  localparam int          INTERNAL_OSC_KHZ = 4000;

  typedef enum logic [2:0] {
    low_power_crystal_mode  = 3'h0,
    crystal_mode            = 3'h1,
    high_speed_crystal_mode = 3'h2,
    external_clock_mode     = 3'h3,
    internal_osc_io_mode    = 3'h4,
    internal_osc_mode       = 3'h5,
    rc_io_mode              = 3'h6,
    rc_divclk_mode          = 3'h7
  } osc_mode_t;

  typedef struct packed {
    logic      data_protect_on;
    logic      program_protect_on;
    logic      brownout_detect_en;
    logic      reset_pin_is_reset;
    logic      powerup_timer_on;
    logic      watchdog_en;
    osc_mode_t osc_mode_select;
    logic [1:0] bandgap_trim;
  } cfg_t;

  typedef struct packed {
    logic osc_in_is_clock;
    logic osc_in_is_io;
    logic osc_out_is_divclk;
    logic osc_out_is_io;
    logic osc_out_is_crystal;
    logic uses_internal_osc;
    logic needs_startup_timer;
  } pin_use_t;
endpackage

//--- cfg_osc_decode.sv
// oscillator mode to pin use decoder, purely combinational
// assumes the mode code comes from a stable configuration register
`timescale 1ns/1ps
`default_nettype none
module cfg_osc_decode (
  // mode in
  input  wire cfg_pkg::osc_mode_t mode_i,
  // pin usage out
  output cfg_pkg::pin_use_t       use_o
);
  // map each of the eight modes to pin functions
  always_comb begin
    use_o = '0;
    case (mode_i)
      cfg_pkg::rc_divclk_mode: begin
        use_o.osc_in_is_clock   = 1'b1;
        use_o.osc_out_is_divclk = 1'b1;
      end
      cfg_pkg::rc_io_mode: begin
        use_o.osc_in_is_clock = 1'b1;
        use_o.osc_out_is_io   = 1'b1;
      end
      cfg_pkg::internal_osc_mode: begin
        use_o.osc_in_is_io      = 1'b1;
        use_o.osc_out_is_divclk = 1'b1;
        use_o.uses_internal_osc = 1'b1;
      end
      cfg_pkg::internal_osc_io_mode: begin
        use_o.osc_in_is_io      = 1'b1;
        use_o.osc_out_is_io     = 1'b1;
        use_o.uses_internal_osc = 1'b1;
      end
      cfg_pkg::external_clock_mode: begin
        use_o.osc_in_is_clock = 1'b1;
        use_o.osc_out_is_io   = 1'b1;
      end
      // crystal or driven clock on input pin
      default: begin
        use_o.osc_in_is_clock     = 1'b1;
        use_o.osc_out_is_crystal  = 1'b1;
        use_o.needs_startup_timer = 1'b1;
      end
    endcase
  end
endmodule
`default_nettype wire

//--- cfg_word_loader.sv
// configuration word store and decoder with oscillator trim loader
// assumes the programmer port is used only in programming mode and
// that the oscillator clock input is asynchronous to clock_i
`timescale 1ns/1ps
`default_nettype none
module cfg_word_loader #(
  parameter int START_CYCLES = cfg_pkg::OSC_START_CYCLES
) (
  // clock and reset
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  // programmer port
  input  wire logic               prog_mode_i,
  input  wire logic               prog_wr_i,
  input  wire logic               prog_rd_i,
  input  wire logic [13:0]        prog_addr_i,
  input  wire logic [13:0]        prog_wdata_i,
  output logic      [13:0]        prog_rdata_o,
  output logic                    prog_ack_o,
  // normal-execution access attempt
  input  wire logic               cpu_rd_i,
  input  wire logic [13:0]        cpu_addr_i,
  output logic                    cpu_denied_o,
  // calibration load from last program word
  input  wire logic               cal_load_i,
  input  wire logic [13:0]        cal_word_i,
  output logic                    cal_bad_o,
  // trim register writes from software
  input  wire logic               trim_wr_i,
  input  wire logic [7:0]         trim_wdata_i,
  output logic      [7:0]         osc_trim_register_o,
  // start-up timing
  input  wire logic               osc_clk_i,
  input  wire logic               startup_begin_i,
  output logic                    startup_done_o,
  // decoded settings
  output cfg_pkg::cfg_t           cfg_o,
  output cfg_pkg::pin_use_t       pin_use_o,
  output logic                    divided_clock_output_o
);
  logic [13:0]              configuration_word_reg;
  logic [7:0]               trim_reg;
  logic [1:0]               osc_sync_reg;
  logic                     osc_prev_reg;
  logic [10:0]              start_cnt_reg;
  logic [1:0]               div_reg;
  logic                     divclk_reg;
  logic [13:0]              rdata_reg;
  logic                     ack_reg;
  logic                     denied_reg;
  logic                     bad_reg;
  logic                     osc_rise;
  logic                     in_special;
  logic                     cpu_special;
  cfg_pkg::cfg_t            cfg;
  cfg_pkg::pin_use_t        pin_use;

  typedef enum logic [1:0] {st_idle, st_count, st_done} start_state_t;
  start_state_t start_state_reg;

  // special configuration range test
  function automatic logic is_special(input logic [13:0] a);
    is_special = (a >= cfg_pkg::SPECIAL_LO) && (a <= cfg_pkg::SPECIAL_HI);
  endfunction

  assign in_special  = is_special(prog_addr_i);
  assign cpu_special = is_special(cpu_addr_i);

  // word store at its fixed address
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      configuration_word_reg <= cfg_pkg::CONFIG_RESET;
    end else if (prog_mode_i && prog_wr_i && prog_addr_i == cfg_pkg::CONFIG_ADDR) begin
      configuration_word_reg <= prog_wdata_i & cfg_pkg::CONFIG_IMPL;
    end
  end

  // programmer read answer, special range only
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_reg <= 14'h0000;
      ack_reg   <= 1'b0;
    end else begin
      ack_reg <= prog_mode_i && (prog_rd_i || prog_wr_i) && in_special;
      if (prog_mode_i && prog_rd_i && prog_addr_i == cfg_pkg::CONFIG_ADDR) begin
        rdata_reg <= configuration_word_reg;
      end else if (prog_mode_i && prog_rd_i) begin
        rdata_reg <= 14'h0000;
      end
    end
  end

  // normal execution refused in special range
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      denied_reg <= 1'b0;
    end else begin
      denied_reg <= cpu_rd_i && !prog_mode_i && cpu_special;
    end
  end

  always_comb begin
    cfg.data_protect_on    = !configuration_word_reg[cfg_pkg::BIT_DATA_PROT];
    cfg.program_protect_on = !configuration_word_reg[cfg_pkg::BIT_PROG_PROT];
    cfg.brownout_detect_en = configuration_word_reg[cfg_pkg::BIT_BROWNOUT];
    cfg.reset_pin_is_reset = configuration_word_reg[cfg_pkg::BIT_RESET_PIN];
    cfg.powerup_timer_on   = !configuration_word_reg[cfg_pkg::BIT_POWERUP];
    cfg.watchdog_en        = configuration_word_reg[cfg_pkg::BIT_WATCHDOG];
    cfg.osc_mode_select    = cfg_pkg::osc_mode_t'(
      configuration_word_reg[cfg_pkg::BIT_OSC_SEL_LO +: 3]);
    cfg.bandgap_trim       = configuration_word_reg[cfg_pkg::BIT_BG_LO +: 2];
  end

  // mode to pin use
  cfg_osc_decode u_decode (
    .mode_i (cfg.osc_mode_select),
    .use_o  (pin_use)
  );

  // check return-with-literal, load literal into trim
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      trim_reg <= cfg_pkg::TRIM_RESET;
      bad_reg  <= 1'b0;
    end else if (cal_load_i) begin
      if (cal_word_i[13:8] == cfg_pkg::RET_LIT_OPCODE) begin
        trim_reg <= cal_word_i[7:0];
        bad_reg  <= 1'b0;
      end else begin
        bad_reg <= 1'b1;
      end
    end else if (trim_wr_i) begin
      trim_reg <= trim_wdata_i;
    end
  end

  // oscillator input synchroniser
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      osc_sync_reg <= 2'b00;
      osc_prev_reg <= 1'b0;
    end else begin
      osc_sync_reg <= {osc_sync_reg[0], osc_clk_i};
      osc_prev_reg <= osc_sync_reg[1];
    end
  end

  assign osc_rise = osc_sync_reg[1] && !osc_prev_reg;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      start_state_reg <= st_idle;
      start_cnt_reg   <= 11'h000;
    end else begin
      case (start_state_reg)
        st_idle: begin
          if (startup_begin_i) begin
            start_cnt_reg   <= 11'h000;
            start_state_reg <= pin_use.needs_startup_timer ? st_count : st_done;
          end
        end
        st_count: begin
          if (osc_rise) begin
            if (start_cnt_reg == 11'(START_CYCLES - 1)) begin
              start_state_reg <= st_done;
            end
            start_cnt_reg <= start_cnt_reg + 11'h001;
          end
        end
        default: begin
          if (startup_begin_i) begin
            start_cnt_reg   <= 11'h000;
            start_state_reg <= pin_use.needs_startup_timer ? st_count : st_done;
          end
        end
      endcase
    end
  end

  // divide oscillator by four for clock-out
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      div_reg    <= 2'b00;
      divclk_reg <= 1'b0;
    end else if (osc_rise) begin
      div_reg    <= div_reg + 2'b01;
      divclk_reg <= pin_use.osc_out_is_divclk && div_reg[1];
    end else if (!pin_use.osc_out_is_divclk) begin
      divclk_reg <= 1'b0;
    end
  end

  // outputs
  assign prog_rdata_o           = rdata_reg;
  assign prog_ack_o             = ack_reg;
  assign cpu_denied_o           = denied_reg;
  assign cal_bad_o              = bad_reg;
  assign osc_trim_register_o    = trim_reg;
  assign startup_done_o         = (start_state_reg == st_done);
  assign cfg_o                  = cfg;
  assign pin_use_o              = pin_use;
  assign divided_clock_output_o = divclk_reg;

  // programmer write lands in the word next cycle
  property p_word_write;
    @(posedge clock_i) disable iff (rst_i)
    prog_mode_i && prog_wr_i && prog_addr_i == cfg_pkg::CONFIG_ADDR
      |=> configuration_word_reg == ($past(prog_wdata_i) & cfg_pkg::CONFIG_IMPL);
  endproperty
  a_word_write: assert property (p_word_write) else $error("config write lost");

  property p_no_write_outside;
    @(posedge clock_i) disable iff (rst_i)
    !prog_mode_i |=> $stable(configuration_word_reg);
  endproperty
  a_no_write_outside: assert property (p_no_write_outside) else $error("config changed");

  property p_cpu_denied;
    @(posedge clock_i) disable iff (rst_i)
    cpu_rd_i && !prog_mode_i && cpu_special |=> cpu_denied_o;
  endproperty
  a_cpu_denied: assert property (p_cpu_denied) else $error("cpu access not denied");

  property p_data_prot;
    @(posedge clock_i) disable iff (rst_i)
    cfg_o.data_protect_on == !configuration_word_reg[8];
  endproperty
  a_data_prot: assert property (p_data_prot) else $error("data protect polarity");

  property p_prog_prot;
    @(posedge clock_i) disable iff (rst_i)
    cfg_o.program_protect_on == !configuration_word_reg[7];
  endproperty
  a_prog_prot: assert property (p_prog_prot) else $error("program protect polarity");

  property p_powerup_timer_wdt;
    @(posedge clock_i) disable iff (rst_i)
    cfg_o.powerup_timer_on != configuration_word_reg[4] &&
    cfg_o.watchdog_en == configuration_word_reg[3] &&
    cfg_o.brownout_detect_en == configuration_word_reg[6] &&
    cfg_o.reset_pin_is_reset == configuration_word_reg[5];
  endproperty
  a_powerup_timer_wdt: assert property (p_powerup_timer_wdt) else $error("enable bit decode");

  property p_divclk_modes;
    @(posedge clock_i) disable iff (rst_i)
    pin_use_o.osc_out_is_divclk == (configuration_word_reg[2:0] == 3'h7 ||
                                    configuration_word_reg[2:0] == 3'h5);
  endproperty
  a_divclk_modes: assert property (p_divclk_modes) else $error("clock-out mode");

  property p_cal_load;
    @(posedge clock_i) disable iff (rst_i)
    cal_load_i && cal_word_i[13:8] == cfg_pkg::RET_LIT_OPCODE
      |=> osc_trim_register_o == $past(cal_word_i[7:0]);
  endproperty
  a_cal_load: assert property (p_cal_load) else $error("trim not loaded");

  sequence s_start_count;
    start_state_reg == st_idle && startup_begin_i && pin_use.needs_startup_timer;
  endsequence
  property p_startup_wait;
    @(posedge clock_i) disable iff (rst_i)
    s_start_count |=> !startup_done_o [*8];
  endproperty
  a_startup_wait: assert property (p_startup_wait) else $error("start-up too early");

  property p_divclk_quiet;
    @(posedge clock_i) disable iff (rst_i)
    !pin_use.osc_out_is_divclk [*2] |-> !divided_clock_output_o;
  endproperty
  a_divclk_quiet: assert property (p_divclk_quiet) else $error("clock-out in io mode");

  // in a clock-out mode the divided clock moves only on a synced oscillator edge
  property p_divclk_step;
    @(posedge clock_i) disable iff (rst_i)
    !osc_rise && pin_use.osc_out_is_divclk |=> $stable(divided_clock_output_o);
  endproperty
  a_divclk_step: assert property (p_divclk_step) else $error("clock-out off step");

  // no answer to the programmer outside the special range
  property p_ack_range;
    @(posedge clock_i) disable iff (rst_i)
    prog_mode_i && (prog_rd_i || prog_wr_i) && !in_special |=> !prog_ack_o;
  endproperty
  a_ack_range: assert property (p_ack_range) else $error("answer outside range");

  // a word that is not return-with-literal leaves the trim alone
  property p_bad_word;
    @(posedge clock_i) disable iff (rst_i)
    cal_load_i && cal_word_i[13:8] != cfg_pkg::RET_LIT_OPCODE
      |=> cal_bad_o && $stable(osc_trim_register_o);
  endproperty
  a_bad_word: assert property (p_bad_word) else $error("bad word accepted");

  property p_trim_write;
    @(posedge clock_i) disable iff (rst_i)
    trim_wr_i && !cal_load_i |=> osc_trim_register_o == $past(trim_wdata_i);
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim write lost");

  // modes without start-up timer finish at once
  sequence s_start_skip;
    start_state_reg == st_idle && startup_begin_i && !pin_use.needs_startup_timer;
  endsequence
  property p_start_skip;
    @(posedge clock_i) disable iff (rst_i)
    s_start_skip |=> startup_done_o;
  endproperty
  a_start_skip: assert property (p_start_skip) else $error("start-up not skipped");
endmodule
`default_nettype wire

//--- cfg_programmer_model.sv
// programmer model: drives the loader's programming port and holds the
// last program word; assumes every strobe is answered one clock later
`timescale 1ns/1ps
`default_nettype none
module cfg_programmer_model (
  // clock
  input  wire logic        clock_i,
  // programming port
  output logic             prog_mode_o,
  output logic             prog_wr_o,
  output logic             prog_rd_o,
  output logic [13:0]      prog_addr_o,
  output logic [13:0]      prog_wdata_o,
  input  wire logic [13:0] prog_rdata_i,
  input  wire logic        prog_ack_i,
  // last program word
  output logic [13:0]      cal_word_o
);
  logic [13:0] saved_cal;

  initial begin
    prog_mode_o  = 1'b0;
    prog_wr_o    = 1'b0;
    prog_rd_o    = 1'b0;
    prog_addr_o  = 14'h1555;
    prog_wdata_o = 14'h2AAA;
    cal_word_o   = {cfg_pkg::RET_LIT_OPCODE, 8'hA5};
    saved_cal    = 14'h0000;
  end

  // mode entry, only a test asks to leave it
  task automatic enter(input logic m);
    @(negedge clock_i);
    prog_mode_o = m;
  endtask

  // one strobe, answer taken one clock later, strobes then dropped and address and data inverted
  task automatic xfer(input logic w, input logic [13:0] a, input logic [13:0] d,
                      output logic [13:0] q, output logic ack);
    @(negedge clock_i);
    prog_addr_o  = a;
    prog_wdata_o = d;
    prog_wr_o    = w;
    prog_rd_o    = !w;
    @(negedge clock_i);
    ack          = prog_ack_i;
    q            = prog_rdata_i;
    prog_wr_o    = 1'b0;
    prog_rd_o    = 1'b0;
    prog_addr_o  = ~a;
    prog_wdata_o = ~d;
  endtask

  task automatic erase_part;
    @(negedge clock_i);
    saved_cal  = cal_word_o;
    cal_word_o = 14'h3FFF;
  endtask

  task automatic restore_cal;
    @(negedge clock_i);
    cal_word_o = saved_cal;
  endtask
endmodule
`default_nettype wire

//--- config_word_osc_select_test.sv
// testbench for the configuration word loader
// assumes the programmer model drives the programming port
`timescale 1ns/1ps
`default_nettype none
module config_word_osc_select_test;
  logic clock_i = 0, rst_i = 1, cpu_rd_i = 0, cal_load_i = 0, trim_wr_i = 0;
  logic osc_clk_i = 0, startup_begin_i = 0, osc_run = 1, a;
  logic prog_mode_i, prog_wr_i, prog_rd_i, prog_ack_o, cpu_denied_o, cal_bad_o;
  logic startup_done_o, divided_clock_output_o;
  logic [13:0] prog_addr_i, prog_wdata_i, prog_rdata_o, cal_word_i, q, w;
  logic [13:0] cpu_addr_i = 14'h0000;
  logic [7:0]  trim_wdata_i = 8'h00, osc_trim_register_o;
  cfg_pkg::cfg_t     cfg_o;
  cfg_pkg::pin_use_t pin_use_o;
  int fails = 0, total_checks = 0, orr, dr;
  logic [13:0] cpu_a [4] = '{14'h1FFF, 14'h2000, 14'h3FFF, 14'h03FF};
  logic [3:0]  cpu_x = 4'b0110;

  always #20 clock_i = ~clock_i;
  // oscillator offset from the clock edges
  initial begin
    #7;
    forever #120 osc_clk_i = osc_run ? ~osc_clk_i : 1'b0;
  end

  cfg_programmer_model prog (.clock_i(clock_i), .prog_mode_o(prog_mode_i),
    .prog_wr_o(prog_wr_i), .prog_rd_o(prog_rd_i), .prog_addr_o(prog_addr_i),
    .prog_wdata_o(prog_wdata_i), .prog_rdata_i(prog_rdata_o), .prog_ack_i(prog_ack_o),
    .cal_word_o(cal_word_i));

  cfg_word_loader #(.START_CYCLES(8)) dut (.clock_i(clock_i), .rst_i(rst_i),
    .prog_mode_i(prog_mode_i), .prog_wr_i(prog_wr_i), .prog_rd_i(prog_rd_i),
    .prog_addr_i(prog_addr_i), .prog_wdata_i(prog_wdata_i), .prog_rdata_o(prog_rdata_o),
    .prog_ack_o(prog_ack_o), .cpu_rd_i(cpu_rd_i), .cpu_addr_i(cpu_addr_i),
    .cpu_denied_o(cpu_denied_o), .cal_load_i(cal_load_i), .cal_word_i(cal_word_i),
    .cal_bad_o(cal_bad_o), .trim_wr_i(trim_wr_i), .trim_wdata_i(trim_wdata_i),
    .osc_trim_register_o(osc_trim_register_o), .osc_clk_i(osc_clk_i),
    .startup_begin_i(startup_begin_i), .startup_done_o(startup_done_o), .cfg_o(cfg_o),
    .pin_use_o(pin_use_o), .divided_clock_output_o(divided_clock_output_o));

  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // expected settings, zero means programmed
  function automatic cfg_pkg::cfg_t exp_cfg(input logic [13:0] v);
    cfg_pkg::cfg_t c;
    c.data_protect_on    = ~v[8];
    c.program_protect_on = ~v[7];
    c.brownout_detect_en = v[6];
    c.reset_pin_is_reset = v[5];
    c.powerup_timer_on   = ~v[4];
    c.watchdog_en        = v[3];
    c.osc_mode_select    = cfg_pkg::osc_mode_t'(v[2:0]);
    c.bandgap_trim       = v[13:12];
    return c;
  endfunction

  // expected pin use of each oscillator code
  function automatic cfg_pkg::pin_use_t exp_pins(input logic [2:0] m);
    cfg_pkg::pin_use_t p;
    p.osc_in_is_clock     = (m != 3'h4) && (m != 3'h5);
    p.osc_in_is_io        = (m == 3'h4) || (m == 3'h5);
    p.osc_out_is_divclk   = (m == 3'h7) || (m == 3'h5);
    p.osc_out_is_io       = (m == 3'h6) || (m == 3'h4) || (m == 3'h3);
    p.osc_out_is_crystal  = (m <= 3'h2);
    p.uses_internal_osc   = (m == 3'h4) || (m == 3'h5);
    p.needs_startup_timer = (m <= 3'h2);
    return p;
  endfunction

  task automatic set_word(input logic [13:0] v);
    prog.xfer(1'b1, cfg_pkg::CONFIG_ADDR, v, q, a);
  endtask

  // strobe calibration load and trim write together or alone
  task automatic trim_op(input logic ld, input logic wr, input logic [7:0] d);
    @(negedge clock_i);
    cal_load_i   = ld;
    trim_wr_i    = wr;
    trim_wdata_i = d;
    @(negedge clock_i);
    cal_load_i   = 1'b0;
    trim_wr_i    = 1'b0;
    trim_wdata_i = ~d;
  endtask

  // count oscillator and divided clock rising edges over a window
  task automatic measure;
    logic po, pd;
    orr = 0;
    dr  = 0;
    po  = osc_clk_i;
    pd  = divided_clock_output_o;
    repeat (400) begin
      @(negedge clock_i);
      if (osc_clk_i && !po) orr++;
      if (divided_clock_output_o && !pd) dr++;
      po = osc_clk_i;
      pd = divided_clock_output_o;
    end
  endtask

  // wait for n oscillator rising edges, bounded
  task automatic osc_rises(input int n);
    int k;
    logic p;
    k = 0;
    p = osc_clk_i;
    for (int c = 0; c < 400 && k < n; c++) begin
      @(negedge clock_i);
      if (osc_clk_i && !p) k++;
      p = osc_clk_i;
    end
    if (k < n) fails++;
  endtask

  initial begin
    repeat (50000) @(posedge clock_i);
    fails++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge clock_i);
    @(negedge clock_i) rst_i = 1'b0;
    chk(cfg_o, exp_cfg(14'h31FF));
    chk(osc_trim_register_o, 8'h80);
    prog.enter(1'b1);
    prog.xfer(1'b0, cfg_pkg::CONFIG_ADDR, 14'h0000, q, a);
    chk(q, 14'h31FF);
    // every oscillator code with alternating field values
    for (int i = 0; i < 8; i++) begin
      w = (i[0] ? 14'h2AA8 : 14'h1550) | 14'(i);
      set_word(w);
      chk(a, 1'b1);
      chk(cfg_o, exp_cfg(w));
      chk(pin_use_o, exp_pins(i[2:0]));
      prog.xfer(1'b0, cfg_pkg::CONFIG_ADDR, 14'h0000, q, a);
      chk(q, w & 14'h31FF);
    end
    prog.xfer(1'b1, 14'h2006, 14'h0000, q, a);
    chk(a, 1'b1);
    chk(cfg_o, exp_cfg(w & 14'h31FF));
    prog.xfer(1'b0, cfg_pkg::LAST_PROG_ADDR, 14'h0000, q, a);
    chk(a, 1'b0);
    prog.enter(1'b0);
    prog.xfer(1'b1, cfg_pkg::CONFIG_ADDR, 14'h0000, q, a);
    chk(a, 1'b0);
    chk(cfg_o, exp_cfg(w & 14'h31FF));
    // normal-execution reads around the special range
    for (int i = 0; i < 4; i++) begin
      @(negedge clock_i);
      cpu_rd_i   = 1'b1;
      cpu_addr_i = cpu_a[i];
      @(negedge clock_i);
      cpu_rd_i   = 1'b0;
      chk(cpu_denied_o, cpu_x[i]);
    end
    prog.enter(1'b1);
    // clock-out modes divide by four, io mode stays low
    set_word(14'h31FF);
    measure();
    chk((dr * 4 <= orr + 4) && (dr * 4 + 4 >= orr) && dr > 0, 1'b1);
    set_word(14'h31FD);
    measure();
    chk((dr * 4 <= orr + 4) && (dr * 4 + 4 >= orr) && dr > 0, 1'b1);
    set_word(14'h31FE);
    measure();
    chk(dr, 0);
    // start-up count in a crystal mode
    set_word(14'h31FA);
    osc_run = 1'b0;
    repeat (4) @(negedge clock_i);
    startup_begin_i = 1'b1;
    @(negedge clock_i) startup_begin_i = 1'b0;
    osc_run = 1'b1;
    osc_rises(7);
    repeat (4) @(negedge clock_i);
    chk(startup_done_o, 1'b0);
    osc_rises(1);
    for (int n = 0; n < 8 && startup_done_o !== 1'b1; n++) @(negedge clock_i);
    chk(startup_done_o, 1'b1);
    // calibration literal, erase and restore, trim writes
    prog.erase_part();
    trim_op(1'b1, 1'b0, 8'h00);
    chk(cal_bad_o, 1'b1);
    prog.restore_cal();
    trim_op(1'b1, 1'b0, 8'h00);
    chk(cal_bad_o, 1'b0);
    chk(osc_trim_register_o, 8'hA5);
    trim_op(1'b0, 1'b1, 8'h5A);
    chk(osc_trim_register_o, 8'h5A);
    trim_op(1'b1, 1'b1, 8'h3C);
    chk(osc_trim_register_o, 8'hA5);
    // second reset in mid-run
    @(negedge clock_i) rst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    rst_i = 1'b0;
    chk(cfg_o, exp_cfg(14'h31FF));
    chk(osc_trim_register_o, 8'h80);
    // external clock mode skips the start-up count
    set_word(14'h31FB);
    chk(startup_done_o, 1'b0);
    @(negedge clock_i) startup_begin_i = 1'b1;
    @(negedge clock_i) startup_begin_i = 1'b0;
    chk(startup_done_o, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
